// file: prs_pkg.sv
// Purpose: shared constants and types for the pixel readout sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: step lengths are cycle counts at the core clock
package prs_pkg;
    localparam int PRS_MODE_W = 2;
    localparam int PRS_ROW_W = 10;
    localparam int PRS_CNT_W = 16;
    localparam logic [PRS_MODE_W-1:0] PRS_MODE_NORMAL = 2'h0;
    localparam logic [PRS_MODE_W-1:0] PRS_MODE_REVERSE = 2'h1;
    localparam logic [PRS_MODE_W-1:0] PRS_MODE_ADAPTIVE = 2'h2;
    localparam logic [PRS_MODE_W-1:0] PRS_MODE_SNAPSHOT = 2'h3;
    localparam logic [PRS_CNT_W-1:0] PRS_STEP_DEFAULT = 16'h0004;
    localparam logic [PRS_CNT_W-1:0] PRS_INTEG_DEFAULT = 16'h0040;
    localparam logic [PRS_ROW_W-1:0] PRS_ROWS_DEFAULT = 10'h3ff;

    typedef enum logic [3:0] {
        PRS_IDLE = 4'h0,
        PRS_RESET = 4'h1,
        PRS_INTEG = 4'h2,
        PRS_GSAMPLE = 4'h3,
        PRS_SELECT = 4'h4,
        PRS_READ1 = 4'h5,
        PRS_XFER = 4'h6,
        PRS_RBIAS = 4'h7,
        PRS_RSETTLE = 4'h8,
        PRS_RSAMPLE = 4'h9,
        PRS_READ2 = 4'ha,
        PRS_NEXT = 4'hb
    } prs_state_t;

    // one step's switch levels: hold and bias
    typedef struct packed {
        logic hold;
        logic bias;
    } prs_sw_t;
endpackage : prs_pkg

// file: prs_row_mem.sv
// Purpose: per-row sample counters for adaptive exposure
// Assumes: single port, registered read data
// Notes: counts adaptive-mode first reads of each row; a first read in any other mode clears it
`timescale 1ns/100ps
`default_nettype none
module prs_row_mem #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 8
) (
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    output logic [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem_reg[addr_in] <= wdata_in;
        end
        rdata_out <= mem_reg[addr_in];
    end
endmodule : prs_row_mem
`default_nettype wire

// file: prs_sequencer.sv
// Purpose: drives row select, hold and bias switches of the pixel array
// Assumes: inputs synchronous to clk_in; analogue differencing is outside
// Notes: master mode runs sequences internally, slave mode passes operator lines
`timescale 1ns/100ps
`default_nettype none
module prs_sequencer
    import prs_pkg::*;
#(
    parameter int ROW_W = prs_pkg::PRS_ROW_W,
    parameter int CNT_W = prs_pkg::PRS_CNT_W
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic master_in,
    input wire logic [prs_pkg::PRS_MODE_W-1:0] mode_in,
    input wire logic start_in,
    input wire logic adaptive_more_in,
    input wire logic [ROW_W-1:0] last_row_in,
    input wire logic [CNT_W-1:0] step_cycles_in,
    input wire logic [CNT_W-1:0] integ_cycles_in,
    input wire logic slave_row_select_in,
    input wire logic [ROW_W-1:0] slave_row_in,
    input wire logic slave_global_pixel_reset_in,
    input wire logic slave_global_transfer_in,
    input wire logic slave_row_reset_in,
    input wire logic slave_row_charge_transfer_in,
    output logic [ROW_W-1:0] row_addr_out,
    output logic row_select_out,
    output logic global_pixel_reset_out,
    output logic global_transfer_out,
    output logic row_reset_out,
    output logic row_charge_transfer_out,
    output logic read_strobe_out,
    output logic read_second_out,
    output logic subtract_out,
    output logic busy_out,
    output logic frame_done_out,
    output logic [7:0] row_samples_out
);
    import prs_pkg::*;

    prs_state_t state_reg;
    prs_state_t state_next;
    logic [PRS_MODE_W-1:0] mode_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [ROW_W-1:0] row_reg;
    logic adaptive_seen_reg;
    logic hold_reg;
    logic bias_reg;
    logic global_reg;
    logic sel_reg;
    logic read_reg;
    logic second_reg;
    logic mem_we;
    logic [7:0] mem_rdata;
    logic [7:0] mem_wdata;
    prs_sw_t sw;

    function automatic logic step_done(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] len);
        step_done = (cnt + 1'b1 >= len);
    endfunction : step_done

    // method steps from mode
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PRS_IDLE: begin
                if (start_in && master_in) begin
                    state_next = (mode_in == PRS_MODE_REVERSE) ? PRS_INTEG : PRS_RESET;
                    if (mode_in == PRS_MODE_ADAPTIVE && adaptive_seen_reg) begin
                        state_next = PRS_INTEG;
                    end
                end
            end
            PRS_RESET: if (step_done(cnt_reg, step_cycles_in)) state_next = PRS_INTEG;
            PRS_INTEG: begin
                if (step_done(cnt_reg, integ_cycles_in)) begin
                    state_next = (mode_reg == PRS_MODE_SNAPSHOT || mode_reg == PRS_MODE_ADAPTIVE)
                        ? PRS_GSAMPLE : PRS_SELECT;
                end
            end
            PRS_GSAMPLE: begin
                if (step_done(cnt_reg, step_cycles_in)) begin
                    state_next = (mode_reg == PRS_MODE_ADAPTIVE && adaptive_more_in)
                        ? PRS_INTEG : PRS_SELECT;
                end
            end
            PRS_SELECT: if (step_done(cnt_reg, step_cycles_in)) state_next = PRS_READ1;
            PRS_READ1: begin
                state_next = (mode_reg == PRS_MODE_NORMAL) ? PRS_XFER : PRS_RBIAS;
                if (mode_reg == PRS_MODE_ADAPTIVE) state_next = PRS_XFER;
            end
            PRS_XFER: begin
                if (step_done(cnt_reg, step_cycles_in)) begin
                    state_next = (mode_reg == PRS_MODE_ADAPTIVE) ? PRS_RBIAS : PRS_READ2;
                end
            end
            PRS_RBIAS: if (step_done(cnt_reg, step_cycles_in)) state_next = PRS_RSETTLE;
            PRS_RSETTLE: if (step_done(cnt_reg, step_cycles_in)) state_next = PRS_RSAMPLE;
            PRS_RSAMPLE: if (step_done(cnt_reg, step_cycles_in)) state_next = PRS_READ2;
            PRS_READ2: state_next = PRS_NEXT;
            PRS_NEXT: begin
                state_next = (row_reg == last_row_in) ? PRS_IDLE : PRS_SELECT;
                if (row_reg != last_row_in && mode_reg != PRS_MODE_SNAPSHOT
                    && mode_reg != PRS_MODE_ADAPTIVE) begin
                    state_next = PRS_SELECT;
                end
            end
            default: state_next = PRS_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_reg <= PRS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || state_next != state_reg) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mode_reg <= PRS_MODE_NORMAL;
        end else if (state_reg == PRS_IDLE && start_in) begin
            mode_reg <= mode_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            row_reg <= '0;
        end else if (state_reg == PRS_IDLE) begin
            row_reg <= '0;
        end else if (state_reg == PRS_NEXT && row_reg != last_row_in) begin
            row_reg <= row_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            adaptive_seen_reg <= 1'b0;
        end else if (state_reg == PRS_IDLE && start_in) begin
            adaptive_seen_reg <= (mode_in == PRS_MODE_ADAPTIVE);
        end else if (state_reg == PRS_RBIAS) begin
            adaptive_seen_reg <= 1'b0;
        end
    end

    // switch levels per step; reading steps keep bias low
    always_comb begin
        sw = '{hold: 1'b0, bias: 1'b0};
        unique case (state_reg)
            PRS_RESET: sw = '{hold: 1'b1, bias: 1'b1};
            PRS_GSAMPLE: sw = '{hold: 1'b1, bias: 1'b0};
            PRS_XFER: sw = '{hold: 1'b1, bias: 1'b0};
            PRS_RBIAS: sw = '{hold: 1'b1, bias: 1'b1};
            PRS_RSAMPLE: sw = '{hold: 1'b1, bias: 1'b0};
            PRS_INTEG: sw = '{hold: (mode_reg == PRS_MODE_REVERSE), bias: 1'b0};
            PRS_SELECT: sw = '{hold: (mode_reg == PRS_MODE_REVERSE), bias: 1'b0};
            PRS_READ1: sw = '{hold: (mode_reg == PRS_MODE_REVERSE), bias: 1'b0};
            default: sw = '{hold: 1'b0, bias: 1'b0};
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            hold_reg <= 1'b0;
            bias_reg <= 1'b0;
            global_reg <= 1'b0;
            sel_reg <= 1'b0;
            read_reg <= 1'b0;
            second_reg <= 1'b0;
        end else begin
            hold_reg <= sw.hold;
            bias_reg <= sw.bias && state_next != PRS_READ1 && state_next != PRS_READ2;
            // frame reset clears every row, so later rows also start from the reset level
            global_reg <= (state_reg == PRS_RESET)
                || ((mode_reg == PRS_MODE_SNAPSHOT || mode_reg == PRS_MODE_ADAPTIVE)
                && (state_reg == PRS_INTEG || state_reg == PRS_GSAMPLE));
            sel_reg <= (state_reg >= PRS_SELECT && state_reg <= PRS_READ2);
            read_reg <= (state_reg == PRS_READ1 || state_reg == PRS_READ2);
            second_reg <= (state_reg == PRS_READ2);
        end
    end

    // first reads count up in adaptive mode, first reads in any other mode clear the row's count
    assign mem_we = (state_reg == PRS_READ1);
    assign mem_wdata = (mode_reg == PRS_MODE_ADAPTIVE) ? mem_rdata + 8'h01 : 8'h00;

    prs_row_mem #(
        .ADDR_W(ROW_W),
        .DATA_W(8)
    ) u_samples (
        .clk_in(clk_in),
        .we_in(mem_we),
        .addr_in(row_reg),
        .wdata_in(mem_wdata),
        .rdata_out(mem_rdata)
    );

    // source of each line: controller, or operator for row and switch lines; read and status lines held low for operator
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            row_addr_out <= '0;
            row_select_out <= 1'b0;
            global_pixel_reset_out <= 1'b0;
            global_transfer_out <= 1'b0;
            row_reset_out <= 1'b0;
            row_charge_transfer_out <= 1'b0;
            read_strobe_out <= 1'b0;
            read_second_out <= 1'b0;
            subtract_out <= 1'b0;
            busy_out <= 1'b0;
            frame_done_out <= 1'b0;
            row_samples_out <= 8'h00;
        end else if (master_in) begin
            row_addr_out <= row_reg;
            row_select_out <= sel_reg;
            global_pixel_reset_out <= bias_reg && global_reg;
            global_transfer_out <= hold_reg && global_reg;
            row_reset_out <= bias_reg && !global_reg;
            row_charge_transfer_out <= hold_reg && !global_reg;
            read_strobe_out <= read_reg;
            read_second_out <= second_reg;
            subtract_out <= second_reg && mode_reg != PRS_MODE_ADAPTIVE;
            busy_out <= state_reg != PRS_IDLE;
            frame_done_out <= state_reg == PRS_NEXT && row_reg == last_row_in;
            row_samples_out <= mem_rdata;
        end else begin
            row_addr_out <= slave_row_in;
            row_select_out <= slave_row_select_in;
            global_pixel_reset_out <= slave_global_pixel_reset_in;
            global_transfer_out <= slave_global_transfer_in;
            row_reset_out <= slave_row_reset_in;
            row_charge_transfer_out <= slave_row_charge_transfer_in;
            read_strobe_out <= 1'b0;
            read_second_out <= 1'b0;
            subtract_out <= 1'b0;
            busy_out <= 1'b0;
            frame_done_out <= 1'b0;
            row_samples_out <= 8'h00;
        end
    end
endmodule : prs_sequencer
`default_nettype wire

// file: prs_pixel_model.sv
// Purpose: behavioural pixel array behind the switch lines, two rows
// Assumes: diode level grows one count per cycle while bias is off
// Notes: unselected reads give the inverted storage value
`timescale 1ns/100ps
`default_nettype none
module prs_pixel_model (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic row_addr_in,
    input wire logic row_select_in,
    input wire logic global_pixel_reset_in,
    input wire logic global_transfer_in,
    input wire logic row_reset_in,
    input wire logic row_charge_transfer_in,
    input wire logic read_strobe_in,
    input wire logic read_second_in,
    output logic [15:0] first_out,
    output logic [15:0] second_out
);
    logic [15:0] pd [2];
    logic [15:0] ss [2];
    logic [1:0] bias;
    logic [1:0] hold;
    logic [15:0] sense;
    always_comb begin
        for (int r = 0; r < 2; r++) begin
            bias[r] = global_pixel_reset_in | (row_reset_in & (row_addr_in == 1'(r)));
            hold[r] = global_transfer_in | (row_charge_transfer_in & (row_addr_in == 1'(r)));
        end
        // hold closed joins diode and site; open reads the site
        sense = hold[row_addr_in] ? pd[row_addr_in] : ss[row_addr_in];
        if (!row_select_in) begin
            sense = ~ss[row_addr_in];
        end
    end
    always_ff @(posedge clk_in) begin
        for (int r = 0; r < 2; r++) begin
            if (reset_in) begin
                pd[r] <= 16'h0;
                ss[r] <= 16'h0;
            end else begin
                pd[r] <= bias[r] ? 16'h0 : pd[r] + 16'h1;
                if (hold[r]) begin
                    ss[r] <= bias[r] ? 16'h0 : pd[r];
                end
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (read_second_in) begin
            second_out <= sense;
        end else if (read_strobe_in) begin
            first_out <= sense;
        end
    end
endmodule : prs_pixel_model
`default_nettype wire

// file: prs_seq_properties.sv
// Purpose: port-level checks of the sequencer
// Assumes: one clock domain, synchronous reset
// Notes: slave lines reach the outputs one clock late
`timescale 1ns/100ps
`default_nettype none
module prs_seq_checker (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic master_in,
    input wire logic start_in,
    input wire logic slave_row_select_in,
    input wire logic slave_row_reset_in,
    input wire logic row_select_out,
    input wire logic global_pixel_reset_out,
    input wire logic global_transfer_out,
    input wire logic row_reset_out,
    input wire logic row_charge_transfer_out,
    input wire logic read_strobe_out,
    input wire logic read_second_out,
    input wire logic subtract_out,
    input wire logic busy_out,
    input wire logic frame_done_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    AST_NO_BIAS_READ: assert property ((read_strobe_out || read_second_out) |->
        !row_reset_out && !global_pixel_reset_out) else $error("bias during read");
    AST_READ_SELECTED: assert property ((read_strobe_out || read_second_out) && master_in |->
        row_select_out) else $error("read without row select");
    AST_SUB_SECOND: assert property (subtract_out |-> read_second_out)
        else $error("subtract outside second read");
    AST_BUSY_CAUSE: assert property ($rose(busy_out) |-> $past(start_in, 2) && $past(master_in, 2))
        else $error("busy without taken start");
    AST_DONE_PULSE: assert property (frame_done_out |=> !frame_done_out)
        else $error("frame done longer than one cycle");
    AST_RESET_QUIET: assert property ($past(reset_in) |-> !busy_out && !row_select_out &&
        !read_strobe_out && !row_reset_out && !global_pixel_reset_out) else $error("outputs live after reset");
    AST_ROW_BIAS_HOLD: assert property (master_in && $past(master_in) && $past(master_in, 2) &&
        row_reset_out |-> row_charge_transfer_out) else $error("row bias without hold");
    AST_GLOBAL_BIAS_HOLD: assert property (master_in && $past(master_in) && $past(master_in, 2) &&
        global_pixel_reset_out |-> global_transfer_out) else $error("global bias without hold");
    AST_SLAVE_PASS: assert property (!master_in && !$past(master_in) &&
        !$past(reset_in) |-> row_select_out == $past(slave_row_select_in) &&
        row_reset_out == $past(slave_row_reset_in)) else $error("slave line not passed through");
endmodule : prs_seq_checker
bind prs_sequencer prs_seq_checker u_chk (.clk_in, .reset_in, .master_in, .start_in, .slave_row_select_in,
    .slave_row_reset_in, .row_select_out, .global_pixel_reset_out, .global_transfer_out, .row_reset_out,
    .row_charge_transfer_out, .read_strobe_out, .read_second_out, .subtract_out, .busy_out, .frame_done_out);
`default_nettype wire

// file: pixel_readout_sequencer_tb.sv
// Purpose: runs every mode against the pixel model, then slave passthrough
// Assumes: two rows, short step and integration lengths
// Notes: outputs sampled at the edge, before that edge's updates land
`timescale 1ns/100ps
`default_nettype none
module pixel_readout_sequencer_tb;
    import prs_pkg::*;
    logic clk_in = 0, reset_in = 1, master_in = 1, start_in = 0, more = 0;
    logic [1:0] mode = 2'h0;
    logic [4:0] sl = 5'h0;
    logic [9:0] sl_row = 10'h0, row_addr;
    logic sel, grst, gx, rrst, rx, rstb, rsec, sub, busy, done;
    logic [7:0] samples;
    logic [15:0] first, second;
    int fails = 0, num_checks = 0, subs, gxr, busy_n;
    prs_sequencer DUT (.clk_in, .reset_in, .master_in, .mode_in(mode), .start_in, .adaptive_more_in(more),
        .last_row_in(10'h1), .step_cycles_in(16'h2), .integ_cycles_in(16'h14), .slave_row_select_in(sl[4]),
        .slave_row_in(sl_row), .slave_global_pixel_reset_in(sl[3]), .slave_global_transfer_in(sl[2]),
        .slave_row_reset_in(sl[1]), .slave_row_charge_transfer_in(sl[0]), .row_addr_out(row_addr),
        .row_select_out(sel), .global_pixel_reset_out(grst), .global_transfer_out(gx), .row_reset_out(rrst),
        .row_charge_transfer_out(rx), .read_strobe_out(rstb), .read_second_out(rsec), .subtract_out(sub),
        .busy_out(busy), .frame_done_out(done), .row_samples_out(samples));
    prs_pixel_model u_pix (.clk_in, .reset_in, .row_addr_in(row_addr[0]), .row_select_in(sel),
        .global_pixel_reset_in(grst), .global_transfer_in(gx), .row_reset_in(rrst),
        .row_charge_transfer_in(rx), .read_strobe_in(rstb), .read_second_in(rsec), .first_out(first),
        .second_out(second));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : check
    task automatic run_frame(input logic [1:0] m);
        int n;
        logic gp;
        repeat (4) @(posedge clk_in);
        mode <= m;
        more <= 1'b1;
        start_in <= 1'b1;
        @(posedge clk_in);
        start_in <= 1'b0;
        subs = 0; gxr = 0; busy_n = 0; n = 0; gp = 1'b0;
        while (done !== 1'b1) begin
            @(posedge clk_in);
            n++;
            if (sub === 1'b1) subs++;
            if (busy === 1'b1) busy_n++;
            if (gx === 1'b1 && gp !== 1'b1) gxr++;
            gp = gx;
            if (n == 150) more <= 1'b0;
            if (n > 5000) begin
                fails++;
                give_verdict();
            end
        end
        // model latches the last second read on the edge after done
        @(posedge clk_in);
    endtask : run_frame
    initial begin
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            run_frame(2'(m));
            check("busy", 16'h1, {15'h0, busy_n > 0});
            case (m)
                0: begin
                    check("normal_first", 16'h0, first);
                    check("normal_order", 16'h1, {15'h0, second > first});
                    check("normal_sub", 16'h1, {15'h0, subs > 0});
                end
                1: check("reverse_order", 16'h1, {15'h0, first > second});
                2: begin
                    check("adaptive_resample", 16'h1, {15'h0, gxr >= 2});
                    check("adaptive_nosub", 16'h0, 16'(subs));
                    check("adaptive_count", 16'h1, {8'h0, samples});
                end
                default: begin
                    check("snap_order", 16'h1, {15'h0, first > second});
                    check("snap_global", 16'h1, {15'h0, gxr >= 1});
                end
            endcase
        end
        master_in <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            sl <= p[0] ? 5'h0a : 5'h15;
            sl_row <= p[0] ? 10'h15a : 10'h2a5;
            start_in <= 1'b1;
            repeat (4) @(posedge clk_in);
            check("slave_lines", {11'h0, p[0] ? 5'h0a : 5'h15}, {11'h0, sel, grst, gx, rrst, rx});
            check("slave_row", {6'h0, p[0] ? 10'h15a : 10'h2a5}, {6'h0, row_addr});
            check("slave_start", 16'h0, {15'h0, busy});
            check("slave_samples", 16'h0, {8'h0, samples});
        end
        give_verdict();
    end
endmodule : pixel_readout_sequencer_tb
`default_nettype wire
